// ### logic/bit_error_tester_cfg.svh
`ifndef BIT_ERROR_TESTER_CFG_SVH
`define BIT_ERROR_TESTER_CFG_SVH

// register offsets (byte addresses, one word each)
`define BET_OFF_CTRL 8'h00
`define BET_OFF_PULSE 8'h04
`define BET_OFF_STATUS 8'h08
`define BET_OFF_RXBITS_LO 8'h0C
`define BET_OFF_RXBITS_HI 8'h10
`define BET_OFF_ERRS 8'h14
`define BET_OFF_RATIO 8'h18
`define BET_OFF_TXFREQ 8'h1C
`define BET_OFF_TXFREQ2 8'h20
`define BET_OFF_LINERATE 8'h24
`define BET_OFF_CFG_ADDR 8'h28
`define BET_OFF_CFG_DATA 8'h2C
`define BET_OFF_PORT_OUT 8'h30
`define BET_OFF_PORT_IN 8'h34

// control register fields
`define BET_CTRL_TXPAT_LSB 0
`define BET_CTRL_RXPAT_LSB 4
`define BET_CTRL_LOOP_LSB 8
`define BET_CTRL_TXPOL 12
`define BET_CTRL_RXPOL 13
`define BET_CTRL_RESET 32'h00000000

// pulse register bits
`define BET_PULSE_INJECT 0
`define BET_PULSE_CNTRST 1
`define BET_PULSE_CHRST 2

// channel reset pulse length in cycles
`define BET_CHRST_CYCLES 8'h10

// frequency measurement window: 1 ms at 40 MHz
`define BET_REF_HZ 40000000
`define BET_WINDOW_US 1000
`define BET_WINDOW_CYCLES ((`BET_REF_HZ / 1000000) * `BET_WINDOW_US)

// checker resyncs only when a word shows more wrong bits than this,
// so a single injected error never knocks it off the sequence
`define BET_RESYNC_BITS 32'd1

// ratio fixed point: fraction bits of the reported ratio
`define BET_RATIO_FRAC 32

`endif

// ### logic/bit_error_tester_pkg.sv
package bit_error_tester_pkg;

	// pattern codes for generator and checker
	typedef enum logic [2:0]
	{
		PAT_PRBS7 = 3'h0,
		PAT_PRBS15 = 3'h1,
		PAT_PRBS23 = 3'h2,
		PAT_PRBS31 = 3'h3,
		PAT_CLK2 = 3'h4,
		PAT_CLK10 = 3'h5
	} pattern_t;

	// loopback mode codes driven to the transceiver
	typedef enum logic [2:0]
	{
		LOOP_NONE = 3'h0,
		LOOP_NEAR_PCS = 3'h1,
		LOOP_NEAR_PMA = 3'h2,
		LOOP_FAR_PMA = 3'h4,
		LOOP_FAR_PCS = 3'h5,
		LOOP_FAR_FABRIC = 3'h6
	} loop_t;

	// register port request
	typedef struct packed
	{
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// transceiver dynamic_reconfig_port request
	typedef struct packed
	{
		logic en;
		logic we;
		logic [8:0] addr;
		logic [15:0] di;
	} cfg_req_t;

	// transceiver dynamic_reconfig_port answer
	typedef struct packed
	{
		logic rdy;
		logic [15:0] dout;
	} cfg_rsp_t;

endpackage : bit_error_tester_pkg

// ### logic/bit_error_tester.sv
// The plain strobed port and the register addresses are this design's own decisions.
`include "bit_error_tester_cfg.svh"

// Behaviour
// RL1: PRBS 7, 15, 23, 31 selectable per side
// RL2: clock patterns divide-by-2 and divide-by-10
// RL3: inject flips one bit of one word
// RL4: far checker sees exactly one error
// RL5: count received bits and bit errors
// RL6: counter reset clears counts, not channel
// RL7: no loopback: paths independent
// RL8: near coding loopback skips physical layer
// RL9: near physical loopback through both layers
// RL10: far physical loopback pins to pins
// RL11: far coding loopback through coding layer
// RL12: far fabric loopback through shallow FIFO
// RL13: channel reset clears layers and fabric
// RL14: transmit polarity inverts every bit
// RL15: receive polarity inverts before checking
// RL16: report link state and line rate
// RL17: report channel or quad PLL lock
// RL18: measure both transmit user clocks, MHz
// RL19: config port writes immediate, reads back
// RL20: only control ports exposed, some read-only
// RL21: inject is one-shot per request
// RL22: ratio is errors over bits, zero-safe
module bit_error_tester
(
	input wire logic clk,
	input wire logic srst,
	input bit_error_tester_pkg::reg_req_t req,
	output logic [31:0] rdata,
	output logic [19:0] tx_data,
	input wire logic [19:0] rx_data,
	input wire logic rx_linked,
	input wire logic [15:0] rx_line_rate,
	input wire logic channel_pll_locked,
	input wire logic quad_shared_pll_locked,
	input wire logic tx_user_clock,
	input wire logic tx_fabric_user_clock,
	output logic [2:0] loopback,
	output logic tx_polarity,
	output logic rx_polarity,
	output logic channel_reset,
	output bit_error_tester_pkg::cfg_req_t cfg_req,
	input bit_error_tester_pkg::cfg_rsp_t cfg_rsp,
	output logic [15:0] port_out,
	input wire logic [15:0] port_in
);
	import bit_error_tester_pkg::*;

	// software control word
	logic [31:0] ctrl;
	// decoded settings
	pattern_t tx_pat;
	pattern_t rx_pat;
	// one-shot strobes from the pulse register
	logic inject_req;
	logic cnt_rst;
	// channel reset stretch counter
	logic [7:0] chrst_cnt;
	// generator and checker state
	logic [30:0] tx_lfsr;
	logic [30:0] rx_lfsr;
	logic [3:0] clk_phase;
	logic [19:0] next_word;
	logic [19:0] rx_word;
	// previous received word, older history for long sequences
	logic [19:0] rx_prev;
	logic [19:0] rx_expect;
	logic [19:0] err_bits;
	// counters
	logic [47:0] rx_bits;
	logic [31:0] err_cnt;
	logic [31:0] ratio;
	// clock measurement
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [15:0] edges_a;
	logic [15:0] edges_b;
	logic [15:0] freq_a;
	logic [15:0] freq_b;
	logic [31:0] window;
	// config port read latch
	logic [15:0] cfg_rd;
	logic cfg_busy;

	assign tx_pat = pattern_t'(ctrl[`BET_CTRL_TXPAT_LSB +: 3]);
	assign rx_pat = pattern_t'(ctrl[`BET_CTRL_RXPAT_LSB +: 3]);

	// advance an lfsr by 20 bits for the chosen order
	function automatic logic [30:0] lfsr_step(input logic [30:0] s, input pattern_t p);
		logic [30:0] v;
		logic fb;
		v = s;
		for (int i = 0; i < 20; i++)
		begin
			unique case (p)
				PAT_PRBS7: fb = v[6] ^ v[5];
				PAT_PRBS15: fb = v[14] ^ v[13];
				PAT_PRBS23: fb = v[22] ^ v[17];
				default: fb = v[30] ^ v[27];
			endcase
			v = {v[29:0], fb};
		end
		return v;
	endfunction : lfsr_step

	// word produced from state for a pattern
	function automatic logic [19:0] pat_word(input logic [30:0] s, input pattern_t p, input logic [3:0] ph);
		logic [19:0] w;
		w = s[19:0];
		// divide-by-2 toggle and divide-by-10 clock patterns
		if (p == PAT_CLK2)
			w = 20'hAAAAA;
		else if (p == PAT_CLK10)
			w = 20'h003FF;
		return w;
	endfunction : pat_word

	// control register write
	always_ff @(posedge clk)
	begin
		if (srst)
			ctrl <= `BET_CTRL_RESET;
		else if (req.wr && req.addr == `BET_OFF_CTRL)
			ctrl <= req.wdata;
	end

	// one-shot pulses, one cycle per write
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			inject_req <= 1'b0;
			cnt_rst <= 1'b0;
		end
		else
		begin
			// RL21: single pulse per request
			inject_req <= req.wr && req.addr == `BET_OFF_PULSE && req.wdata[`BET_PULSE_INJECT];
			cnt_rst <= req.wr && req.addr == `BET_OFF_PULSE && req.wdata[`BET_PULSE_CNTRST];
		end
	end

	// settings driven to the transceiver
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			loopback <= LOOP_NONE;
			tx_polarity <= 1'b0;
			rx_polarity <= 1'b0;
			port_out <= 16'h0000;
		end
		else
		begin
			// RL7: mode code selects feedback path
			// RL8: RL9: RL10: RL11: RL12: modes passed to the channel
			loopback <= ctrl[`BET_CTRL_LOOP_LSB +: 3];
			// RL14: transmit polarity control
			tx_polarity <= ctrl[`BET_CTRL_TXPOL];
			// RL15: receive polarity control
			rx_polarity <= ctrl[`BET_CTRL_RXPOL];
			// RL20: writable control ports
			if (req.wr && req.addr == `BET_OFF_PORT_OUT)
				port_out <= req.wdata[15:0];
		end
	end

	// channel reset held for a fixed number of cycles
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			chrst_cnt <= 8'h00;
			channel_reset <= 1'b0;
		end
		else
		begin
			// RL13: reset whole channel and fabric side
			if (req.wr && req.addr == `BET_OFF_PULSE && req.wdata[`BET_PULSE_CHRST])
				chrst_cnt <= `BET_CHRST_CYCLES;
			else if (chrst_cnt != 8'h00)
				chrst_cnt <= chrst_cnt - 8'h01;
			channel_reset <= chrst_cnt != 8'h00;
		end
	end

	// transmit generator
	always_comb
	begin
		next_word = pat_word(tx_lfsr, tx_pat, clk_phase);
		// RL3: flip bit zero of this word only
		if (inject_req)
			next_word[0] = ~next_word[0];
	end

	always_ff @(posedge clk)
	begin
		if (srst || channel_reset)
		begin
			tx_lfsr <= 31'h7FFFFFFF;
			clk_phase <= 4'h0;
			tx_data <= 20'h00000;
		end
		else
		begin
			// RL1: generator lfsr for selected order
			tx_lfsr <= lfsr_step(tx_lfsr, tx_pat);
			// RL2: clock pattern phase
			clk_phase <= clk_phase + 4'h1;
			tx_data <= next_word;
		end
	end

	// receive checker self-seeds from the last two incoming words
	assign rx_word = rx_data;
	assign rx_expect = pat_word(rx_lfsr, rx_pat, 4'h0);
	assign err_bits = rx_word ^ rx_expect;

	// keep one word of history: orders 23 and 31 need more than 20 bits
	always_ff @(posedge clk)
	begin
		if (srst || channel_reset)
			rx_prev <= 20'h00000;
		else
			rx_prev <= rx_word;
	end

	always_ff @(posedge clk)
	begin
		if (srst || channel_reset)
			rx_lfsr <= 31'h7FFFFFFF;
		// RL1: checker follows received sequence
		else if (32'($countones(err_bits)) > `BET_RESYNC_BITS)
			rx_lfsr <= lfsr_step({rx_prev[10:0], rx_word}, rx_pat);
		else
			rx_lfsr <= lfsr_step(rx_lfsr, rx_pat);
	end

	// bit and error counters
	always_ff @(posedge clk)
	begin
		// RL6: counters only, channel untouched
		if (srst || cnt_rst)
		begin
			rx_bits <= 48'h0;
			err_cnt <= 32'h0;
		end
		else if (rx_linked)
		begin
			// RL5: running bit and error counts
			rx_bits <= rx_bits + 48'd20;
			// RL4: one per flipped bit
			err_cnt <= err_cnt + 32'($countones(err_bits));
		end
	end

	// ratio in 0.32 fixed point, zero while no bits seen
	always_ff @(posedge clk)
	begin
		if (srst || cnt_rst || rx_bits == 48'h0)
			// RL22: zero when no bits
			ratio <= 32'h0;
		else
			ratio <= 32'(({16'h0, err_cnt, 32'h0}) / {32'h0, rx_bits});
	end

	// transmit user clock frequency count over a 1 ms window
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
			edges_a <= 16'h0;
			edges_b <= 16'h0;
			freq_a <= 16'h0;
			freq_b <= 16'h0;
			window <= 32'h0;
		end
		else
		begin
			sync_a <= {sync_a[1:0], tx_user_clock};
			sync_b <= {sync_b[1:0], tx_fabric_user_clock};
			// RL18: edges per ms over 1000 is MHz
			if (window == 32'(`BET_WINDOW_CYCLES - 1))
			begin
				window <= 32'h0;
				freq_a <= edges_a / 16'd1000;
				freq_b <= edges_b / 16'd1000;
				edges_a <= 16'h0;
				edges_b <= 16'h0;
			end
			else
			begin
				window <= window + 32'h1;
				if (sync_b[2] != sync_b[1] && sync_b[1])
					edges_b <= edges_b + 16'h1;
				if (sync_a[2] != sync_a[1] && sync_a[1])
					edges_a <= edges_a + 16'h1;
			end
		end
	end

	// config port: write goes out at once, read is latched
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cfg_req <= '0;
			cfg_rd <= 16'h0;
			cfg_busy <= 1'b0;
		end
		else
		begin
			cfg_req.en <= 1'b0;
			cfg_req.we <= 1'b0;
			if (req.wr && req.addr == `BET_OFF_CFG_ADDR)
			begin
				// RL19: address write starts a read back
				cfg_req.addr <= req.wdata[8:0];
				cfg_req.en <= 1'b1;
				cfg_busy <= 1'b1;
			end
			else if (req.wr && req.addr == `BET_OFF_CFG_DATA)
			begin
				// RL19: data write applied immediately
				cfg_req.di <= req.wdata[15:0];
				cfg_req.en <= 1'b1;
				cfg_req.we <= 1'b1;
				cfg_rd <= req.wdata[15:0];
			end
			if (cfg_rsp.rdy && cfg_busy)
			begin
				cfg_rd <= cfg_rsp.dout;
				cfg_busy <= 1'b0;
			end
		end
	end

	// read mux, data one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (srst)
			rdata <= 32'h0;
		else if (req.rd)
		begin
			unique case (req.addr)
				`BET_OFF_CTRL: rdata <= ctrl;
				// RL16: RL17: link and lock state
				`BET_OFF_STATUS: rdata <= {28'h0, cfg_busy, quad_shared_pll_locked, channel_pll_locked, rx_linked};
				`BET_OFF_RXBITS_LO: rdata <= rx_bits[31:0];
				`BET_OFF_RXBITS_HI: rdata <= {16'h0, rx_bits[47:32]};
				`BET_OFF_ERRS: rdata <= err_cnt;
				`BET_OFF_RATIO: rdata <= ratio;
				`BET_OFF_TXFREQ: rdata <= {16'h0, freq_a};
				`BET_OFF_TXFREQ2: rdata <= {16'h0, freq_b};
				// RL16: line rate only when linked
				`BET_OFF_LINERATE: rdata <= rx_linked ? {16'h0, rx_line_rate} : 32'h0;
				`BET_OFF_CFG_ADDR: rdata <= {23'h0, cfg_req.addr};
				`BET_OFF_CFG_DATA: rdata <= {16'h0, cfg_rd};
				`BET_OFF_PORT_OUT: rdata <= {16'h0, port_out};
				// RL20: read-only ports
				`BET_OFF_PORT_IN: rdata <= {16'h0, port_in};
				default: rdata <= 32'h0;
			endcase
		end
		else
			rdata <= 32'h0;
	end

endmodule : bit_error_tester

// ### tb/bit_error_tester_sva.sv
module bit_error_tester_sva
(
	input wire logic clk,
	input wire logic srst,
	input bit_error_tester_pkg::reg_req_t req,
	input wire logic [31:0] rdata,
	input wire logic [2:0] loopback,
	input wire logic tx_polarity,
	input wire logic rx_polarity,
	input wire logic channel_reset,
	input bit_error_tester_pkg::cfg_req_t cfg_req,
	input wire logic [15:0] port_out,
	input wire logic [15:0] port_in
);
	import bit_error_tester_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// writes to control and pulse words
	wire ctl_wr = req.wr && req.addr == 8'h00;
	wire pul_wr = req.wr && req.addr == 8'h04;
	property p_loop;
		ctl_wr |-> ##2 loopback == $past(req.wdata[10:8], 2);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback wrong");
	property p_txpol;
		ctl_wr |-> ##2 tx_polarity == $past(req.wdata[12], 2);
	endproperty
	a_txpol: assert property (p_txpol) else $error("tx polarity wrong");
	property p_rxpol;
		ctl_wr |-> ##2 rx_polarity == $past(req.wdata[13], 2);
	endproperty
	a_rxpol: assert property (p_rxpol) else $error("rx polarity wrong");
	property p_chrst;
		pul_wr && req.wdata[2] |-> ##[1:2] channel_reset;
	endproperty
	a_chrst: assert property (p_chrst) else $error("channel reset missing");
	property p_chlen;
		$rose(channel_reset) |-> channel_reset[*8] ##1 channel_reset[*8] ##1 !channel_reset;
	endproperty
	a_chlen: assert property (p_chlen) else $error("channel reset length");
	property p_cfgwr;
		req.wr && req.addr == 8'h2C |-> ##[1:2] cfg_req.en && cfg_req.we;
	endproperty
	a_cfgwr: assert property (p_cfgwr) else $error("config write missing");
	property p_cfgrd;
		req.wr && req.addr == 8'h28 |-> ##[1:2] cfg_req.en && !cfg_req.we;
	endproperty
	a_cfgrd: assert property (p_cfgrd) else $error("config read missing");
	property p_port;
		req.wr && req.addr == 8'h30 |-> ##1 port_out == $past(req.wdata[15:0]);
	endproperty
	a_port: assert property (p_port) else $error("port out wrong");
	property p_portrd;
		req.rd && req.addr == 8'h34 |-> ##1 rdata[15:0] == $past(port_in);
	endproperty
	a_portrd: assert property (p_portrd) else $error("port in wrong");
endmodule : bit_error_tester_sva

bind bit_error_tester bit_error_tester_sva bit_error_tester_sva_i (.clk(clk), .srst(srst), .req(req),
	.rdata(rdata), .loopback(loopback), .tx_polarity(tx_polarity), .rx_polarity(rx_polarity),
	.channel_reset(channel_reset), .cfg_req(cfg_req), .port_out(port_out), .port_in(port_in));

// ### tb/gt_channel_model.sv
module gt_channel_model
(
	input wire logic clk,
	input wire logic [19:0] tx_data,
	input wire logic tx_polarity,
	input wire logic rx_polarity,
	input bit_error_tester_pkg::cfg_req_t cfg_req,
	output bit_error_tester_pkg::cfg_rsp_t cfg_rsp,
	output logic [19:0] rx_data,
	output logic tx_user_clock,
	output logic tx_fabric_user_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	import bit_error_tester_pkg::*;
	logic [15:0] mem [0:511]; // config space
	logic en_q; // read in flight
	logic [8:0] addr_q;
	initial
	begin
		tx_user_clock = 1'b0;
		tx_fabric_user_clock = 1'b0;
		cfg_rsp = '0;
	end
	// 10 MHz and 5 MHz user clocks
	always #50 tx_user_clock = ~tx_user_clock;
	always #100 tx_fabric_user_clock = ~tx_fabric_user_clock;
	always_ff @(posedge clk) rx_data <= tx_data ^ {20{tx_polarity ^ rx_polarity}};
	// config memory, answer two cycles on
	always_ff @(posedge clk)
	begin
		en_q <= cfg_req.en;
		addr_q <= cfg_req.addr;
		if (cfg_req.en && cfg_req.we)
			mem[cfg_req.addr] <= cfg_req.di;
		cfg_rsp.rdy <= en_q;
		// released data bus shows the inverse
		cfg_rsp.dout <= en_q ? mem[addr_q] : ~cfg_rsp.dout;
	end
endmodule : gt_channel_model

// ### tb/bit_error_tester_tb_top.sv
module bit_error_tester_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bit_error_tester_pkg::*;
	typedef struct packed {logic [31:0] ctrl; logic [2:0] lp; logic pol;} row_t;
	logic clk = 1'b0;
	logic srst = 1'b1;
	reg_req_t req = '0;
	logic [31:0] rdata, rd_val, errs;
	logic [63:0] bits, q;
	logic [19:0] tx_data, rx_data;
	logic linked = 1'b1, chan_lock = 1'b1, quad_lock = 1'b0;
	logic txu_clk, txf_clk, tx_pol, rx_pol, ch_rst;
	logic [15:0] port_out, port_in = 16'h5A3C;
	logic [2:0] loopback;
	cfg_req_t cfg_req;
	cfg_rsp_t cfg_rsp;
	int bad_count = 0;
	int cmp_count = 0;
	// every pattern and loop code once
	row_t rows [6] = '{'{32'h00000000, 3'h0, 1'b0}, '{32'h00003111, 3'h1, 1'b1},
		'{32'h00000222, 3'h2, 1'b0}, '{32'h00003433, 3'h4, 1'b1},
		'{32'h00000544, 3'h5, 1'b0}, '{32'h00003655, 3'h6, 1'b1}};
	always #12.5 clk = ~clk;
	bit_error_tester bit_error_tester_i (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
		.tx_data(tx_data), .rx_data(rx_data), .rx_linked(linked), .rx_line_rate(16'h1234),
		.channel_pll_locked(chan_lock), .quad_shared_pll_locked(quad_lock), .tx_user_clock(txu_clk),
		.tx_fabric_user_clock(txf_clk), .loopback(loopback), .tx_polarity(tx_pol), .rx_polarity(rx_pol),
		.channel_reset(ch_rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .port_out(port_out),
		.port_in(port_in));
	gt_channel_model gt_channel_model_i (.clk(clk), .tx_data(tx_data), .tx_polarity(tx_pol),
		.rx_polarity(rx_pol), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .rx_data(rx_data),
		.tx_user_clock(txu_clk), .tx_fabric_user_clock(txf_clk));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
	endtask : wr
	// read data land in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		#1 rd_val = rdata;
	endtask : rd
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// poll the busy flag, bounded
	task automatic wait_cfg;
		for (int n = 0; n < 50; n++)
		begin
			rd(8'h08);
			if (rd_val[3] === 1'b0)
				return;
		end
		bad_count++;
		print_verdict();
	endtask : wait_cfg
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		#1 chk("reset port", 32'h0, {16'h0, port_out});
		foreach (rows[i])
		begin
			wr(8'h00, rows[i].ctrl);
			repeat (30) @(posedge clk);
			chk("loopback", {29'h0, rows[i].lp}, {29'h0, loopback});
			chk("polarity", {30'h0, {2{rows[i].pol}}}, {30'h0, tx_pol, rx_pol});
			wr(8'h04, 32'h2);
			repeat (40) @(posedge clk);
			rd(8'h14);
			chk("clean errors", 32'h0, rd_val);
			$display("test row %0d done", i);
		end
		wr(8'h04, 32'h2);
		wr(8'h04, 32'h1);
		repeat (20) @(posedge clk);
		wr(8'h04, 32'h1);
		repeat (20) @(posedge clk);
		linked <= 1'b0;
		repeat (5) @(posedge clk);
		rd(8'h0C);
		bits[31:0] = rd_val;
		rd(8'h10);
		bits[63:32] = rd_val;
		rd(8'h14);
		errs = rd_val;
		chk("injected errors", 32'h2, errs);
		chk("bit step", 32'h0, 32'(bits % 20));
		q = {errs, 32'h0} / bits;
		rd(8'h18);
		chk("ratio", q[31:0], rd_val);
		rd(8'h24);
		chk("rate unlinked", 32'h0, rd_val);
		wr(8'h04, 32'h2);
		foreach (rows[i])
		begin
			rd(8'h0C + 8'(i * 4));
			chk("cleared", 32'h0, (i < 4) ? rd_val : 32'h0);
		end
		chk("no channel reset", 32'h0, {31'h0, ch_rst});
		linked <= 1'b1;
		rd(8'h24);
		chk("rate", 32'h1234, rd_val);
		rd(8'h08);
		chk("status", 32'h3, {29'h0, rd_val[2:0]});
		$display("test counters done");
		wr(8'h04, 32'h4);
		repeat (2) @(posedge clk);
		chk("channel reset", 32'h1, {31'h0, ch_rst});
		wr(8'h28, 32'h5);
		wait_cfg();
		wr(8'h2C, 32'hBEEF);
		wait_cfg();
		wr(8'h28, 32'h5);
		wait_cfg();
		rd(8'h2C);
		chk("config data", 32'hBEEF, {16'h0, rd_val[15:0]});
		wr(8'h30, 32'hA5C3);
		rd(8'h34);
		chk("port in", 32'h5A3C, rd_val);
		rd(8'h3C);
		chk("unmapped", 32'h0, rd_val);
		$display("test access done");
		repeat (81000) @(posedge clk);
		rd(8'h1C);
		chk("user clock", 32'h1, {31'h0, rd_val >= 9 && rd_val <= 11});
		rd(8'h20);
		chk("fabric clock", 32'h1, {31'h0, rd_val >= 4 && rd_val <= 6});
		$display("test clocks done");
		print_verdict();
	end
endmodule : bit_error_tester_tb_top
